/* File: rtl/afp_pkg.sv */
// Package of constants and types shared by the parallel host port files.
package afp_pkg;
  localparam int          AFP_DATA_W     = 8;
  localparam int          AFP_SYNC_DEPTH = 2;
  localparam logic [7:0]  AFP_DATA_RST   = 8'h00;
  localparam logic        AFP_STB_IDLE   = 1'b1;
  localparam int          AFP_PULSE_CYC  = 1;

  // Operating mode of the eight data lines.
  typedef enum logic [1:0] {
    AFP_MODE_IDLE,
    AFP_MODE_FIFO,
    AFP_MODE_BITBANG
  } afp_mode_t;

  // Read-side sequence of the asynchronous FIFO interface.
  typedef enum logic [1:0] {
    AFP_RD_WAIT,
    AFP_RD_AVAIL,
    AFP_RD_DRIVE,
    AFP_RD_RECOVER
  } afp_rd_t;
endpackage

/* File: rtl/afp_sync.sv */
// Two-stage synchroniser for one asynchronous input level.
module afp_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync_out;

  // The first stage is read only by the second stage.
  always_comb begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  // Registers both stages; reset loads the inactive level.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end
endmodule

/* File: rtl/afp_port.sv */
// Parallel host port: asynchronous FIFO mode and bit-bang mode.
//
// Overview of operation
// - FIFO bytes move on strobe falling edges.
// - FIFO-mode data lines input except while read low.
// - Receive flag low only when byte readable.
// - Read rising edge raises flag; relower if more.
// - Transmit flag low when a byte can be accepted.
// - Read fall presents byte; rise fetches next.
// - Write falling edge captures data byte.
// - Flags undriven during reset, float high.
// - Wakeup strobe during suspend requests resume if remote wakeup enabled.
// - Send-now strobe raises send_now_req when not suspended.
// - Bit-bang makes lines an 8-bit bus.
// - Pulse update strobe on new output data.
// - Rising sample strobe after lines are read.
// - FIFO mode only when configuration selects it.
// - Bit-bang entered by host mode command.
module afp_port
  import afp_pkg::*;
#(
  parameter int DATA_W = AFP_DATA_W
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [DATA_W-1:0] parallel_data_lines_in,
  output logic      [DATA_W-1:0] parallel_data_lines_out,
  output logic      [DATA_W-1:0] parallel_data_lines_oe,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic              send_now_wakeup_n,
  output logic                   receive_available_n,
  output logic                   receive_available_oe,
  output logic                   transmit_space_n,
  output logic                   transmit_space_oe,
  output logic                   output_update_pulse_n,
  output logic                   input_sample_pulse_n,
  input  wire logic              cfg_async_fifo,
  input  wire logic              cmd_bitbang_valid,
  input  wire logic              cmd_bitbang_enable,
  input  wire logic [DATA_W-1:0] bb_dir_out,
  input  wire logic              rx_valid,
  input  wire logic [DATA_W-1:0] rx_data,
  output logic                   rx_pop,
  input  wire logic              tx_ready,
  output logic                   tx_push,
  output logic      [DATA_W-1:0] tx_data,
  input  wire logic              bb_out_valid,
  input  wire logic [DATA_W-1:0] bb_out_data,
  output logic                   bb_in_valid,
  output logic      [DATA_W-1:0] bb_in_data,
  input  wire logic              bb_sample_req,
  input  wire logic              usb_suspended,
  input  wire logic              remote_wakeup_en,
  output logic                   resume_req,
  output logic                   send_now_req
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic              rd_s;
  logic              wr_s;
  logic              send_now_wakeup_n_s;
  logic [DATA_W-1:0] din_s;

  afp_sync #(.RST_VAL(1'b1)) u_sync_rd (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (read_strobe_n),
    .sync_out (rd_s)
  );
  afp_sync #(.RST_VAL(1'b1)) u_sync_wr (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (write_strobe_n),
    .sync_out (wr_s)
  );
  afp_sync #(.RST_VAL(1'b1)) u_sync_send_now_wakeup_n (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (send_now_wakeup_n),
    .sync_out (send_now_wakeup_n_s)
  );

  // Data lines are synchronised bit by bit; the sender holds them stable.
  for (genvar i = 0; i < DATA_W; i++) begin : g_din
    afp_sync #(.RST_VAL(1'b0)) u_sync_d (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (parallel_data_lines_in[i]),
      .sync_out (din_s[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // State.
  afp_mode_t         mode, next_mode;
  afp_rd_t           rd_st, next_rd_st;
  logic              rd_q, next_rd_q;
  logic              wr_q, next_wr_q;
  logic              send_now_wakeup_n_q, next_send_now_wakeup_n_q;
  logic [DATA_W-1:0] dout, next_dout;
  logic [DATA_W-1:0] doe, next_doe;
  logic              rxf_n, next_rxf_n;
  logic              txe_n, next_txe_n;
  logic              upd_n, next_upd_n;
  logic              smp_n, next_smp_n;
  logic              pop, next_pop;
  logic              push, next_push;
  logic [DATA_W-1:0] txd, next_txd;
  logic              bbv, next_bbv;
  logic [DATA_W-1:0] bbd, next_bbd;
  logic              resume, next_resume;
  logic              sendnow, next_sendnow;
  logic              smp_pend, next_smp_pend;

  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic send_now_wakeup_n_fall;

  assign rd_fall   = rd_q & ~rd_s;
  assign rd_rise   = ~rd_q & rd_s;
  assign wr_fall   = wr_q & ~wr_s;
  assign send_now_wakeup_n_fall = send_now_wakeup_n_q & ~send_now_wakeup_n_s;

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic for mode, FIFO handshakes, bit-bang and wakeup.
  always_comb begin
    next_mode     = mode;
    next_rd_st    = rd_st;
    next_rd_q     = rd_s;
    next_wr_q     = wr_s;
    next_send_now_wakeup_n_q   = send_now_wakeup_n_s;
    next_dout     = dout;
    next_doe      = '0;
    next_rxf_n    = 1'b1;
    next_txe_n    = 1'b1;
    next_upd_n    = AFP_STB_IDLE;
    next_smp_n    = smp_n;
    next_pop      = 1'b0;
    next_push     = 1'b0;
    next_txd      = txd;
    next_bbv      = 1'b0;
    next_bbd      = bbd;
    next_resume   = 1'b0;
    next_sendnow  = 1'b0;
    next_smp_pend = smp_pend;

    // A host command has priority; otherwise the configuration decides, except that bit-bang holds.
    if (cmd_bitbang_valid) begin
      next_mode = cmd_bitbang_enable ? AFP_MODE_BITBANG
                : (cfg_async_fifo ? AFP_MODE_FIFO : AFP_MODE_IDLE);
    end else if (mode == AFP_MODE_IDLE && cfg_async_fifo) begin
      next_mode = AFP_MODE_FIFO;
    end else if (mode == AFP_MODE_FIFO && !cfg_async_fifo) begin
      next_mode = AFP_MODE_IDLE;
    end

    unique case (mode)
      AFP_MODE_FIFO: begin
        // Read side: flag high after each read, low again only with data.
        unique case (rd_st)
          AFP_RD_WAIT: begin
            if (rx_valid && rd_s) begin
              next_rd_st = AFP_RD_AVAIL;
              next_rxf_n = 1'b0;
            end
          end
          AFP_RD_AVAIL: begin
            next_rxf_n = 1'b0;
            if (rd_fall) begin
              next_rd_st = AFP_RD_DRIVE;
              next_dout  = rx_data;
              next_doe   = '1;
            end
          end
          AFP_RD_DRIVE: begin
            next_rxf_n = 1'b0;
            next_doe   = '1;
            if (rd_rise) begin
              next_rd_st = AFP_RD_RECOVER;
              next_rxf_n = 1'b1;
              next_doe   = '0;
              next_pop   = 1'b1;
            end
          end
          AFP_RD_RECOVER: begin
            // One cycle for the popped byte to leave the buffer.
            next_rd_st = AFP_RD_WAIT;
          end
        endcase
        // Write side: space flag follows the transmit buffer.
        next_txe_n = ~tx_ready;
        if (wr_fall && !txe_n) begin
          next_push = 1'b1;
          next_txd  = din_s;
        end
        if (send_now_wakeup_n_fall) begin
          next_resume  = usb_suspended & remote_wakeup_en;
          next_sendnow = ~usb_suspended;
        end
      end
      AFP_MODE_BITBANG: begin
        next_rd_st = AFP_RD_WAIT;
        next_doe   = bb_dir_out;
        // Update pulse lasts one cycle and is never back to back.
        if (bb_out_valid && upd_n) begin
          next_dout  = bb_out_data;
          next_upd_n = 1'b0;
        end
        // Sample strobe: low one cycle, then rise as the value leaves.
        if (!smp_n) begin
          next_smp_n = 1'b1;
          next_bbv   = 1'b1;
          next_bbd   = din_s;
        end else if (bb_sample_req || smp_pend) begin
          next_smp_n    = 1'b0;
          next_smp_pend = 1'b0;
        end
        if (bb_sample_req && !smp_n) begin
          next_smp_pend = 1'b1;
        end
        if (send_now_wakeup_n_fall) begin
          next_resume  = usb_suspended & remote_wakeup_en;
          next_sendnow = ~usb_suspended;
        end
      end
      default: begin
        next_rd_st = AFP_RD_WAIT;
      end
    endcase
    if (mode != AFP_MODE_BITBANG) begin
      next_smp_n    = AFP_STB_IDLE;
      next_smp_pend = 1'b0;
    end
  end

  // Registers; reset gives idle lines and released flags.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode     <= AFP_MODE_IDLE;
      rd_st    <= AFP_RD_WAIT;
      rd_q     <= 1'b1;
      wr_q     <= 1'b1;
      send_now_wakeup_n_q   <= 1'b1;
      dout     <= AFP_DATA_RST;
      doe      <= '0;
      rxf_n    <= 1'b1;
      txe_n    <= 1'b1;
      upd_n    <= AFP_STB_IDLE;
      smp_n    <= AFP_STB_IDLE;
      pop      <= 1'b0;
      push     <= 1'b0;
      txd      <= AFP_DATA_RST;
      bbv      <= 1'b0;
      bbd      <= AFP_DATA_RST;
      resume   <= 1'b0;
      sendnow  <= 1'b0;
      smp_pend <= 1'b0;
    end else begin
      mode     <= next_mode;
      rd_st    <= next_rd_st;
      rd_q     <= next_rd_q;
      wr_q     <= next_wr_q;
      send_now_wakeup_n_q   <= next_send_now_wakeup_n_q;
      dout     <= next_dout;
      doe      <= next_doe;
      rxf_n    <= next_rxf_n;
      txe_n    <= next_txe_n;
      upd_n    <= next_upd_n;
      smp_n    <= next_smp_n;
      pop      <= next_pop;
      push     <= next_push;
      txd      <= next_txd;
      bbv      <= next_bbv;
      bbd      <= next_bbd;
      resume   <= next_resume;
      sendnow  <= next_sendnow;
      smp_pend <= next_smp_pend;
    end
  end

  // Flag enables are a reset-released flop so pins float during reset.
  logic flag_oe, next_flag_oe;
  always_comb begin
    next_flag_oe = (mode == AFP_MODE_FIFO);
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_oe <= 1'b0;
    end else begin
      flag_oe <= next_flag_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.
  assign parallel_data_lines_out = dout;
  assign parallel_data_lines_oe  = doe;
  assign receive_available_n     = rxf_n;
  assign receive_available_oe    = flag_oe;
  assign transmit_space_n        = txe_n;
  assign transmit_space_oe       = flag_oe;
  assign output_update_pulse_n   = upd_n;
  assign input_sample_pulse_n    = smp_n;
  assign rx_pop                  = pop;
  assign tx_push                 = push;
  assign tx_data                 = txd;
  assign bb_in_valid             = bbv;
  assign bb_in_data              = bbd;
  assign resume_req              = resume;
  assign send_now_req            = sendnow;
endmodule

/* File: dv/afp_port_props.sv */
// Checker for the pins and strobes of the parallel host port.
module afp_port_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] parallel_data_lines_oe,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       send_now_wakeup_n,
  input wire logic       receive_available_n,
  input wire logic       receive_available_oe,
  input wire logic       transmit_space_oe,
  input wire logic       output_update_pulse_n,
  input wire logic       input_sample_pulse_n,
  input wire logic       bb_out_valid,
  input wire logic       bb_sample_req,
  input wire logic       bb_in_valid,
  input wire logic       rx_pop,
  input wire logic       tx_push,
  input wire logic       usb_suspended,
  input wire logic       remote_wakeup_en,
  input wire logic       resume_req,
  input wire logic       send_now_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // The sample strobe dips for one cycle, then rises with the data.
  sequence s_smp_low;
    !input_sample_pulse_n;
  endsequence
  sequence s_smp_done;
    input_sample_pulse_n && bb_in_valid;
  endsequence
  chk_drive_on_read: assert property (receive_available_oe &&
    |parallel_data_lines_oe |-> !$past(read_strobe_n, 3) ||
    !$past(read_strobe_n, 4)) else $error("lines driven sans read");
  chk_flag_after_read: assert property ($rose(read_strobe_n) &&
    receive_available_oe |-> ##[1:4] receive_available_n)
    else $error("flag not raised");
  chk_pop_after_read: assert property (rx_pop |->
    receive_available_n &&
    $past(read_strobe_n, 3) && !$past(read_strobe_n, 5))
    else $error("pop out of step");
  chk_push_after_wr: assert property (tx_push |->
    !$past(write_strobe_n, 3) && $past(write_strobe_n, 5) ##1 !tx_push)
    else $error("push out of step");
  chk_flags_reset: assert property (disable iff (1'b0) sys_rst |->
    !receive_available_oe && !transmit_space_oe &&
    parallel_data_lines_oe == 8'h00) else $error("driven in reset");
  chk_update_pulse: assert property (
    $fell(output_update_pulse_n) |->
    $past(bb_out_valid) ##1 output_update_pulse_n)
    else $error("update pulse bad");
  chk_sample_steps: assert property (bb_sample_req &&
    input_sample_pulse_n |=> s_smp_low ##1 s_smp_done)
    else $error("sample pulse bad");
  chk_resume_cause: assert property (resume_req |-> usb_suspended &&
    remote_wakeup_en && !($past(send_now_wakeup_n, 3) &&
    $past(send_now_wakeup_n, 4))) else $error("resume sans cause");
  chk_send_cause: assert property (send_now_req |-> !usb_suspended &&
    !($past(send_now_wakeup_n, 3) && $past(send_now_wakeup_n, 4)))
    else $error("send sans cause");
endmodule

bind afp_port afp_port_props afp_port_props_i (.clk, .sys_rst,
  .parallel_data_lines_oe, .read_strobe_n, .write_strobe_n,
  .send_now_wakeup_n, .receive_available_n, .receive_available_oe,
  .transmit_space_oe, .output_update_pulse_n, .input_sample_pulse_n,
  .bb_out_valid, .bb_sample_req, .bb_in_valid, .rx_pop, .tx_push,
  .usb_suspended, .remote_wakeup_en, .resume_req, .send_now_req);

/* File: dv/afp_ext_ctrl.sv */
// Model of the external controller that strobes the FIFO pins.
module afp_ext_ctrl (
  input  wire logic       clk,
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  input  wire logic       rxf_n,
  input  wire logic       txe_n,
  output logic      [7:0] pins,
  output logic            rd_n,
  output logic            wr_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drv;
  logic       drv_en;
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    drv = 8'h00;
    drv_en = 1'b0;
  end
  // A released bit shows the inverse of our last value, so a float
  // can never pass for the data that the device should drive.
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      pins[b] = dev_oe[b] ? dev_out[b] : (drv_en ? drv[b] : ~drv[b]);
    end
  end
  // Read one byte; blind skips the wait on the receive flag.
  task automatic read_byte(input bit blind, output logic [7:0] got);
    for (int n = 0; n < 40 && rxf_n !== 1'b0 && !blind; n++) begin
      @(negedge clk);
    end
    @(negedge clk);
    rd_n = 1'b0;
    repeat (5) @(negedge clk);
    got = pins;
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  // Write one byte, low then high on the write strobe.
  task automatic write_byte(input bit blind, input logic [7:0] val);
    for (int n = 0; n < 40 && txe_n !== 1'b0 && !blind; n++) begin
      @(negedge clk);
    end
    @(negedge clk);
    drv = val;
    drv_en = 1'b1;
    repeat (3) @(negedge clk);
    wr_n = 1'b0;
    repeat (4) @(negedge clk);
    wr_n = 1'b1;
    repeat (4) @(negedge clk);
    drv_en = 1'b0;
  endtask
  task automatic hold_bus(input logic en, input logic [7:0] val);
    drv = val;
    drv_en = en;
  endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the parallel host port.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import afp_pkg::*;
  // Starting low by declaration avoids a false falling edge at time zero.
  logic clk = 1'b0;
  logic sys_rst, read_strobe_n, write_strobe_n, send_now_wakeup_n;
  logic receive_available_n, receive_available_oe, transmit_space_n;
  logic transmit_space_oe, output_update_pulse_n, input_sample_pulse_n;
  logic cfg_async_fifo, cmd_bitbang_valid, cmd_bitbang_enable, rx_valid;
  logic rx_pop, tx_ready, tx_push, bb_out_valid, bb_in_valid;
  logic bb_sample_req, usb_suspended, remote_wakeup_en, resume_req;
  logic send_now_req;
  logic [7:0] parallel_data_lines_in, parallel_data_lines_out;
  logic [7:0] parallel_data_lines_oe, bb_dir_out, rx_data, tx_data;
  logic [7:0] bb_out_data, bb_in_data, got, last_in;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int failures, comparisons, pops, upd, smp, slo, rsm, snd, cycles;
  afp_port afp_port_i (.*);
  afp_ext_ctrl afp_ext_ctrl_i (.clk, .dev_out(parallel_data_lines_out),
    .dev_oe(parallel_data_lines_oe), .pins(parallel_data_lines_in),
    .rxf_n(receive_available_oe ? receive_available_n : 1'b1),
    .txe_n(transmit_space_oe ? transmit_space_n : 1'b1),
    .rd_n(read_strobe_n), .wr_n(write_strobe_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Receive buffer and event counters, updated off the sampling edge.
  always @(negedge clk) begin
    if (rx_pop === 1'b1 && rxq.size() > 0) void'(rxq.pop_front());
    pops += (rx_pop === 1'b1);
    if (tx_push === 1'b1) txq.push_back(tx_data);
    upd += (output_update_pulse_n === 1'b0);
    if (bb_in_valid === 1'b1) last_in = bb_in_data;
    smp += (bb_in_valid === 1'b1);
    slo += (input_sample_pulse_n === 1'b0);
    rsm += (resume_req === 1'b1);
    snd += (send_now_req === 1'b1);
    rx_valid = rxq.size() != 0;
    rx_data = rx_valid ? rxq[0] : 8'h00;
  end
  // Cuts a hang short; the tests need well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e,
                     input string m);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic t_reset();
    wait_n(6);
    cmp(receive_available_oe, 8'h00, "rx oe");
    cmp(transmit_space_oe, 8'h00, "tx oe");
    cmp(parallel_data_lines_oe, 8'h00, "data oe");
    sys_rst = 1'b0;
    wait_n(4);
    cmp(receive_available_oe, 8'h01, "fifo mode");
    cmp(receive_available_n, 8'h01, "rx flag");
    cmp(transmit_space_n, 8'h00, "tx flag");
  endtask
  // Reset in mid-run with the configuration off, then turned back on.
  task automatic t_rst_mid();
    sys_rst = 1'b1;
    cfg_async_fifo = 1'b0;
    wait_n(2);
    cmp(receive_available_oe, 8'h00, "rx oe mid");
    cmp(transmit_space_oe, 8'h00, "tx oe mid");
    sys_rst = 1'b0;
    wait_n(4);
    cmp(transmit_space_oe, 8'h00, "no cfg");
    cfg_async_fifo = 1'b1;
    wait_n(3);
    cmp(transmit_space_oe, 8'h01, "cfg fifo");
    cmp(transmit_space_n, 8'h00, "tx flag mid");
  endtask
  task automatic t_read();
    rxq = '{8'hA5, 8'h3C};
    afp_ext_ctrl_i.read_byte(1'b0, got);
    cmp(got, 8'hA5, "read 1");
    cmp(parallel_data_lines_oe, 8'h00, "released");
    afp_ext_ctrl_i.read_byte(1'b0, got);
    cmp(got, 8'h3C, "read 2");
    cmp(receive_available_n, 8'h01, "flag high");
    afp_ext_ctrl_i.read_byte(1'b1, got);
    cmp(got, 8'hFF, "refused read");
    cmp(8'(pops), 8'h02, "pops");
  endtask
  task automatic t_write();
    afp_ext_ctrl_i.write_byte(1'b0, 8'h5A);
    afp_ext_ctrl_i.write_byte(1'b0, 8'hC3);
    tx_ready = 1'b0;
    wait_n(6);
    cmp(transmit_space_n, 8'h01, "tx full");
    afp_ext_ctrl_i.write_byte(1'b1, 8'h99);
    tx_ready = 1'b1;
    cmp(8'(txq.size()), 8'h02, "pushes");
    if (txq.size() == 2) begin
      cmp(txq[0], 8'h5A, "tx data 1");
      cmp(txq[1], 8'hC3, "tx data 2");
    end
  endtask
  task automatic t_send_now_wakeup_n();
    for (int k = 0; k < 3; k++) begin
      {usb_suspended, remote_wakeup_en} = 2'(k == 0 ? 0 : k + 1);
      rsm = 0;
      snd = 0;
      send_now_wakeup_n = 1'b0;
      wait_n(5);
      send_now_wakeup_n = 1'b1;
      wait_n(6);
      cmp(8'(snd), 8'(k == 0), "send now");
      cmp(8'(rsm), 8'(k == 2), "resume");
    end
    {usb_suspended, remote_wakeup_en} = 2'b00;
  endtask
  task automatic t_bitbang();
    {cmd_bitbang_valid, cmd_bitbang_enable} = 2'b11;
    wait_n(1);
    cmd_bitbang_valid = 1'b0;
    wait_n(3);
    cmp(receive_available_oe, 8'h00, "bit-bang");
    {bb_dir_out, bb_out_data, bb_out_valid, upd} = {16'hFF96, 1'b1, 32'd0};
    wait_n(1);
    bb_out_valid = 1'b0;
    wait_n(3);
    cmp(parallel_data_lines_in, 8'h96, "bb out");
    cmp(8'(upd), 8'h01, "update");
    bb_dir_out = 8'h00;
    afp_ext_ctrl_i.hold_bus(1'b1, 8'h4B);
    wait_n(3);
    slo = 0;
    {bb_sample_req, smp} = {1'b1, 32'd0};
    wait_n(1);
    bb_sample_req = 1'b0;
    wait_n(4);
    cmp(last_in, 8'h4B, "bb in");
    cmp(8'(smp), 8'h01, "sample");
    cmp(8'(slo), 8'h01, "sample strobe");
    afp_ext_ctrl_i.hold_bus(1'b0, 8'h4B);
    {cmd_bitbang_valid, cmd_bitbang_enable} = 2'b10;
    wait_n(1);
    cmd_bitbang_valid = 1'b0;
    wait_n(4);
    cmp(receive_available_oe, 8'h01, "back to fifo");
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    {send_now_wakeup_n, cfg_async_fifo, tx_ready} = 3'b111;
    {cmd_bitbang_valid, cmd_bitbang_enable, bb_out_valid} = 3'b000;
    {bb_sample_req, usb_suspended, remote_wakeup_en} = 3'b000;
    {bb_dir_out, bb_out_data} = 16'h0000;
    t_reset();
    t_read();
    t_write();
    t_send_now_wakeup_n();
    t_bitbang();
    t_rst_mid();
    wrap_up();
  end
endmodule
